// ==== rtl/scr_device.sv ====
// Decided for this implementation: the plain strobed port.
`include "scr_defs.svh"

module scr_device (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // Register link to both masters
   scr_link_if.device       link,
   // Strap and link status pins
   input  wire logic [6:0]  strapAddress,
   input  wire logic        linkDetected,
   // Raw sync pins
   input  wire logic        dataEnableInput,
   input  wire logic        horizontalSyncInput,
   input  wire logic        verticalSyncInput,
   // Path to remote slaves
   output logic             farReq,
   output logic             farWrite,
   output logic             farPort,
   output logic [7:0]       farAddr,
   output logic [7:0]       farData,
   input  wire logic        farDone,
   input  wire logic        farNack,
   input  wire logic [7:0]  farRdata,
   // Configuration and status
   output logic [6:0]       deviceAddress0,
   output logic [6:0]       deviceAddress1,
   output logic             port1Enabled,
   output logic             powerDown,
   output logic             crcCheckEnable,
   output logic             pclkAutoSwitch,
   output logic             logicResetPulse,
   output logic [2:0]       syncOut
);

   localparam logic [7:0] GeneralReset = `SCR_GENERAL_RESET;
   localparam logic [7:0] PortCtlReset = `SCR_PORT_CONTROL_RESET;
   localparam logic [7:0] SleepReset   = `SCR_RESET_SLEEP_RESET;
   // Second port default address is the strap neighbour
   function automatic logic [6:0] scr_next_addr(input logic [6:0] a);
      scr_next_addr = 7'(a + 7'h01);
   endfunction
   // Pin synchronisers
   logic [6:0]                strapMeta_q;
   logic [6:0]                strapSync_q;
   logic [3:0]                pinMeta_q;
   logic [3:0]                pinSync_q;
   logic [2:0]                pinLast_q;
   logic [2:0]                syncOut_q;
   // Register bank
   logic [1:0][6:0]           addrField_q;
   logic                      addrSource_q;
   logic                      sleep_q;
   logic                      crcEnable_q;
   logic                      pclkAuto_q;
   logic                      filterEnable_q;
   logic [1:0]                autoAck_q;
   logic                      viewSelect_q;
   logic                      port1Enable_q;
   logic                      fullReset_q;
   logic                      keepReset_q;
   // Arbiter, answers and remote path
   logic                      lastGrant_q;
   logic [1:0]                rspValid_q;
   logic [1:0]                rspNack_q;
   logic [1:0][7:0]           rspData_q;
   scr_pkg::scr_far_state_type farState_q;
   logic                      farOwner_q;
   logic                      farAcked_q;
   logic                      farReq_q;
   logic                      farWrite_q;
   logic                      farPort_q;
   logic [7:0]                farAddr_q;
   logic [7:0]                farData_q;
   // Registered outputs
   logic [6:0]                devAddr0_q;
   logic [6:0]                devAddr1_q;
   logic                      powerDown_q;
   logic                      resetPulse_q;

   // Reset scopes: soft full reset also clears registers
   wire regReset   = reset | fullReset_q;
   wire logicReset = regReset | keepReset_q;
   // Arbitration; nothing is taken while soft reset holds the answers
   wire        farBusy = (farState_q == scr_pkg::FAR_WAIT);
   wire [1:0]  pending = link.reqValid & ~rspValid_q
                         & ~(link.reqFar & {2{farBusy}})
                         & ~{2{logicReset}};
   wire [1:0]  grant;
   assign grant[0] = pending[0] & (~pending[1] | lastGrant_q);
   assign grant[1] = pending[1] & ~grant[0];
   wire        sel      = grant[1];
   wire        anyGrant = |grant;
   wire [7:0]  selAddr  = link.reqAddr[sel];
   wire [7:0]  selData  = link.reqData[sel];
   wire        selWrite = link.reqWrite[sel];
   wire        selFar   = link.reqFar[sel];
   wire        selPort  = link.reqPort[sel];
   wire        regTake  = anyGrant & ~selFar;
   wire        regWrite = regTake & selWrite;
   wire        farTake  = anyGrant & selFar & ~farBusy;
   wire        autoAckNow = farTake & selWrite & autoAck_q[selPort];
   // Address decode
   wire        hitAddr  = (selAddr == `SCR_REG_DEVICE_ADDRESS);
   wire        hitReset = (selAddr == `SCR_REG_RESET_SLEEP);
   wire        hitGen   = (selAddr == `SCR_REG_GENERAL_CONFIG);
   wire        hitPort  = (selAddr == `SCR_REG_PORT_CONTROL);
   wire        view     = viewSelect_q;
   // Read back; reserved bits and self-clearing bits read zero
   wire [7:0]  rdAddr  = {addrField_q[view], addrSource_q};
   wire [7:0]  rdReset = {sleep_q, 7'h00};
   wire [7:0]  rdGen   = {crcEnable_q, 1'b0, autoAck_q[view],
                          filterEnable_q, 2'b00, pclkAuto_q, 1'b0};
   wire [7:0]  rdPort  = {6'h00, port1Enable_q, viewSelect_q};
   wire [7:0]  readData = hitAddr  ? rdAddr  :
                          hitReset ? rdReset :
                          hitGen   ? rdGen   :
                          hitPort  ? rdPort  : 8'h00;
   // Sync filter: an edge is taken only once two samples agree
   wire [2:0]  filterTake = filterEnable_q ?
                            ~(pinSync_q[2:0] ^ pinLast_q) : 3'b111;
   // Two-flop synchronisers; first stage feeds only the second.
   // The strap path runs through reset so that reset can catch it.
   always_ff @(posedge ref_clk) begin
      strapMeta_q  <= strapAddress;
      strapSync_q  <= strapMeta_q;
      resetPulse_q <= keepReset_q | fullReset_q;
      if (reset) begin
         pinMeta_q   <= 4'h0;
         pinSync_q   <= 4'h0;
      end else begin
         pinMeta_q   <= {linkDetected, verticalSyncInput,
                         horizontalSyncInput, dataEnableInput};
         pinSync_q   <= pinMeta_q;
      end
   end

   // Register bank; strap is caught while reset is held
   always_ff @(posedge ref_clk) begin
      if (regReset) begin
         addrField_q[0] <= strapSync_q;
         addrField_q[1] <= scr_next_addr(strapSync_q);
         addrSource_q   <= 1'b0;
         sleep_q        <= SleepReset[`SCR_BIT_SLEEP];
         crcEnable_q    <= GeneralReset[`SCR_BIT_CRC_ENABLE];
         pclkAuto_q     <= GeneralReset[`SCR_BIT_PCLK_AUTO];
         filterEnable_q <= GeneralReset[`SCR_BIT_FILTER_ENABLE];
         autoAck_q      <= {2{GeneralReset[`SCR_BIT_AUTO_ACK]}};
         viewSelect_q   <= PortCtlReset[`SCR_BIT_VIEW_SELECT];
         port1Enable_q  <= PortCtlReset[`SCR_BIT_PORT1_ENABLE];
         fullReset_q    <= 1'b0;
         keepReset_q    <= 1'b0;
      end else begin
         fullReset_q <= regWrite & hitReset & selData[`SCR_BIT_FULL_RESET];
         keepReset_q <= regWrite & hitReset & selData[`SCR_BIT_KEEP_RESET];
         if (regWrite && hitAddr) begin
            addrField_q[view] <= selData[7:1];
            addrSource_q      <= selData[`SCR_BIT_ADDR_SOURCE];
         end
         if (regWrite && hitReset) begin
            sleep_q <= selData[`SCR_BIT_SLEEP];
         end
         if (regWrite && hitGen) begin
            crcEnable_q     <= selData[`SCR_BIT_CRC_ENABLE];
            pclkAuto_q      <= selData[`SCR_BIT_PCLK_AUTO];
            filterEnable_q  <= selData[`SCR_BIT_FILTER_ENABLE];
            autoAck_q[view] <= selData[`SCR_BIT_AUTO_ACK];
         end
         if (regWrite && hitPort) begin
            viewSelect_q  <= selData[`SCR_BIT_VIEW_SELECT];
            port1Enable_q <= selData[`SCR_BIT_PORT1_ENABLE];
         end
      end
   end
   // Answers; a remote access cut by soft reset is answered with NACK
   always_ff @(posedge ref_clk) begin
      if (logicReset) begin
         lastGrant_q <= 1'b0;
         rspValid_q  <= (farBusy & ~farAcked_q) ?
                        (2'b01 << farOwner_q) : 2'b00;
         rspNack_q   <= 2'b11;
         rspData_q   <= '0;
      end else begin
         rspValid_q <= 2'b00;
         if (anyGrant) begin
            lastGrant_q <= sel;
         end
         if (regTake || autoAckNow) begin
            rspValid_q[sel] <= 1'b1;
            rspNack_q[sel]  <= 1'b0;
            rspData_q[sel]  <= regTake ? readData : 8'h00;
         end
         if (farBusy && farDone && !farAcked_q) begin
            rspValid_q[farOwner_q] <= 1'b1;
            rspNack_q[farOwner_q]  <= farNack;
            rspData_q[farOwner_q]  <= farRdata;
         end
      end
   end
   // Remote path: one forwarded transaction at a time
   always_ff @(posedge ref_clk) begin
      if (logicReset) begin
         farState_q <= scr_pkg::FAR_IDLE;
         farOwner_q <= 1'b0;
         farAcked_q <= 1'b0;
         farReq_q   <= 1'b0;
         farWrite_q <= 1'b0;
         farPort_q  <= 1'b0;
         farAddr_q  <= 8'h00;
         farData_q  <= 8'h00;
      end else begin
         unique case (farState_q)
            scr_pkg::FAR_IDLE: begin
               if (farTake) begin
                  farState_q <= scr_pkg::FAR_WAIT;
                  farOwner_q <= sel;
                  farAcked_q <= autoAckNow;  // Later NACK is dropped
                  farReq_q   <= 1'b1;
                  farWrite_q <= selWrite;
                  farPort_q  <= selPort;
                  farAddr_q  <= selAddr;
                  farData_q  <= selData;
               end
            end
            scr_pkg::FAR_WAIT: begin
               if (farDone) begin
                  farState_q <= scr_pkg::FAR_IDLE;
                  farReq_q   <= 1'b0;
                  farAcked_q <= 1'b0;
               end
            end
         endcase
      end
   end
   // Sync filter and status outputs
   always_ff @(posedge ref_clk) begin
      if (logicReset) begin
         pinLast_q   <= 3'h0;
         syncOut_q   <= 3'h0;
         devAddr0_q  <= 7'h00;
         devAddr1_q  <= 7'h00;
         powerDown_q <= 1'b0;
      end else begin
         pinLast_q   <= pinSync_q[2:0];
         syncOut_q   <= (syncOut_q & ~filterTake)
                        | (pinSync_q[2:0] & filterTake);
         devAddr0_q  <= addrSource_q ? addrField_q[0]
                                     : strapSync_q;
         devAddr1_q  <= addrSource_q ? addrField_q[1]
                                     : scr_next_addr(strapSync_q);
         powerDown_q <= sleep_q & ~pinSync_q[3];
      end
   end

   // Output drive
   assign link.rspValid   = rspValid_q;
   assign link.rspNack    = rspNack_q;
   assign link.rspData    = rspData_q;
   assign farReq          = farReq_q;
   assign farWrite        = farWrite_q;
   assign farPort         = farPort_q;
   assign farAddr         = farAddr_q;
   assign farData         = farData_q;
   assign deviceAddress0  = devAddr0_q;
   assign deviceAddress1  = devAddr1_q;
   assign port1Enabled    = port1Enable_q;
   assign powerDown       = powerDown_q;
   assign crcCheckEnable  = crcEnable_q;
   assign pclkAutoSwitch  = pclkAuto_q;
   assign logicResetPulse = resetPulse_q;
   assign syncOut         = syncOut_q;

endmodule

// ==== rtl/scr_defs.svh ====
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// Device register offsets
`define SCR_REG_DEVICE_ADDRESS  8'h00
`define SCR_REG_RESET_SLEEP     8'h01
`define SCR_REG_GENERAL_CONFIG  8'h03
`define SCR_REG_PORT_CONTROL    8'h1e

// Device field positions
`define SCR_BIT_ADDR_SOURCE     0
`define SCR_BIT_SLEEP           7
`define SCR_BIT_FULL_RESET      1
`define SCR_BIT_KEEP_RESET      0
`define SCR_BIT_CRC_ENABLE      7
`define SCR_BIT_AUTO_ACK        5
`define SCR_BIT_FILTER_ENABLE   4
`define SCR_BIT_PCLK_AUTO       1
`define SCR_BIT_VIEW_SELECT     0
`define SCR_BIT_PORT1_ENABLE    1

// Device reset values
`define SCR_RESET_SLEEP_RESET   8'h00
`define SCR_GENERAL_RESET       8'hd2
`define SCR_PORT_CONTROL_RESET  8'h00

// Host controller register offsets
`define SCR_HOST_TARGET         8'h00
`define SCR_HOST_WDATA          8'h01
`define SCR_HOST_LAUNCH         8'h02
`define SCR_HOST_STATUS         8'h03
`define SCR_HOST_RDATA0         8'h04
`define SCR_HOST_RDATA1         8'h05
`define SCR_HOST_POLICY         8'h06

// Host controller field positions
`define SCR_LAUNCH_WRITE        0
`define SCR_LAUNCH_MASTER       1
`define SCR_LAUNCH_FAR          2
`define SCR_LAUNCH_PORT         3
`define SCR_STATUS_NACK0        2
`define SCR_STATUS_NACK1        3
`define SCR_STATUS_REFUSED      4
`define SCR_POLICY_OWNER        0
`define SCR_POLICY_LEGACY       1
`define SCR_HOST_POLICY_RESET   8'h00
`endif

// ==== rtl/scr_pkg.sv ====
package scr_pkg;
   typedef logic [7:0] scr_byte_type;
   typedef enum logic {FAR_IDLE, FAR_WAIT} scr_far_state_type;
endpackage

// ==== rtl/scr_link_if.sv ====
// Index 0 is the local master, index 1 the remote master
interface scr_link_if;
   logic [1:0]      reqValid;
   logic [1:0]      reqWrite;
   logic [1:0]      reqFar;
   logic [1:0]      reqPort;
   logic [1:0][7:0] reqAddr;
   logic [1:0][7:0] reqData;
   logic [1:0]      rspValid;
   logic [1:0]      rspNack;
   logic [1:0][7:0] rspData;

   modport device (
      input  reqValid, reqWrite, reqFar, reqPort, reqAddr, reqData,
      output rspValid, rspNack, rspData
   );
   modport host (
      output reqValid, reqWrite, reqFar, reqPort, reqAddr, reqData,
      input  rspValid, rspNack, rspData
   );
endinterface

// ==== rtl/scr_host.sv ====
`include "scr_defs.svh"

module scr_host (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // Register link toward the device
   scr_link_if.host         link,
   // Software command port
   input  wire logic [7:0]  cmdAddr,
   input  wire logic [7:0]  cmdWdata,
   input  wire logic        cmdWrite,
   input  wire logic        cmdRead,
   output logic [7:0]       cmdRdata
);

   localparam logic [7:0] PolicyReset = `SCR_HOST_POLICY_RESET;

   logic [7:0]      target_q;
   logic [7:0]      wdata_q;
   logic            owner_q;
   logic            legacy_q;
   logic            refused_q;
   logic [1:0]      nack_q;
   logic [1:0][7:0] rdata_q;
   logic [1:0]      reqValid_q;
   logic [1:0]      reqWrite_q;
   logic [1:0]      reqFar_q;
   logic [1:0]      reqPort_q;
   logic [1:0][7:0] reqAddr_q;
   logic [1:0][7:0] reqData_q;
   logic [7:0]      cmdRdata_q;

   // Launch decode and refusal checks
   wire launch  = cmdWrite & (cmdAddr == `SCR_HOST_LAUNCH);
   wire lMaster = cmdWdata[`SCR_LAUNCH_MASTER];
   wire lFar    = cmdWdata[`SCR_LAUNCH_FAR];
   wire farLive = |(reqValid_q & reqFar_q);
   wire badDir  = lFar & (owner_q != lMaster);
   wire badReg  = ~lFar & lMaster & legacy_q;
   wire refuse  = launch & (reqValid_q[lMaster] | badDir | badReg);
   wire accept  = launch & ~refuse;
   // A policy write is ignored while a remote access is live
   wire polWr   = cmdWrite & (cmdAddr == `SCR_HOST_POLICY) & ~farLive;
   wire stWr    = cmdWrite & (cmdAddr == `SCR_HOST_STATUS);
   wire [1:0] nackSet = link.rspValid & link.rspNack;
   wire [1:0] nackClr = {2{stWr}}
                        & cmdWdata[`SCR_STATUS_NACK1:`SCR_STATUS_NACK0];
   wire [7:0] status  = {3'h0, refused_q, nack_q, reqValid_q};
   wire [7:0] readMux =
      (cmdAddr == `SCR_HOST_TARGET) ? target_q :
      (cmdAddr == `SCR_HOST_WDATA)  ? wdata_q  :
      (cmdAddr == `SCR_HOST_STATUS) ? status   :
      (cmdAddr == `SCR_HOST_RDATA0) ? rdata_q[0] :
      (cmdAddr == `SCR_HOST_RDATA1) ? rdata_q[1] :
      (cmdAddr == `SCR_HOST_POLICY) ? {6'h00, legacy_q, owner_q} : 8'h00;

   // Software registers; sticky flags let a new event beat the clear
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         target_q   <= 8'h00;
         wdata_q    <= 8'h00;
         owner_q    <= PolicyReset[`SCR_POLICY_OWNER];
         legacy_q   <= PolicyReset[`SCR_POLICY_LEGACY];
         refused_q  <= 1'b0;
         nack_q     <= 2'b00;
         cmdRdata_q <= 8'h00;
      end else begin
         if (cmdWrite && cmdAddr == `SCR_HOST_TARGET) begin
            target_q <= cmdWdata;
         end
         if (cmdWrite && cmdAddr == `SCR_HOST_WDATA) begin
            wdata_q <= cmdWdata;
         end
         if (polWr) begin
            owner_q  <= cmdWdata[`SCR_POLICY_OWNER];
            legacy_q <= cmdWdata[`SCR_POLICY_LEGACY];
         end
         refused_q  <= refuse
                       | (refused_q & ~(stWr & cmdWdata[`SCR_STATUS_REFUSED]));
         nack_q     <= nackSet | (nack_q & ~nackClr);
         cmdRdata_q <= cmdRead ? readMux : 8'h00;
      end
   end

   // Request slots, one per master; held until answered
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reqValid_q <= 2'b00;
         reqWrite_q <= 2'b00;
         reqFar_q   <= 2'b00;
         reqPort_q  <= 2'b00;
         reqAddr_q  <= '0;
         reqData_q  <= '0;
         rdata_q    <= '0;
      end else begin
         for (int m = 0; m < 2; m++) begin
            if (link.rspValid[m]) begin
               reqValid_q[m] <= 1'b0;
               rdata_q[m]    <= link.rspData[m];
            end
         end
         if (accept) begin
            reqValid_q[lMaster] <= 1'b1;
            reqWrite_q[lMaster] <= cmdWdata[`SCR_LAUNCH_WRITE];
            reqFar_q[lMaster]   <= lFar;
            reqPort_q[lMaster]  <= cmdWdata[`SCR_LAUNCH_PORT];
            reqAddr_q[lMaster]  <= target_q;
            reqData_q[lMaster]  <= wdata_q;
         end
      end
   end

   // Output drive
   assign link.reqValid = reqValid_q;
   assign link.reqWrite = reqWrite_q;
   assign link.reqFar   = reqFar_q;
   assign link.reqPort  = reqPort_q;
   assign link.reqAddr  = reqAddr_q;
   assign link.reqData  = reqData_q;
   assign cmdRdata      = cmdRdata_q;

endmodule

// ==== verif/scr_link_assertions.sv ====
module scr_link_assertions (
   // Clock and reset
   input wire logic            ref_clk,
   input wire logic            reset,
   // Link signals
   input wire logic [1:0]      reqValid,
   input wire logic [1:0]      reqWrite,
   input wire logic [1:0]      reqFar,
   input wire logic [1:0][7:0] reqAddr,
   input wire logic [1:0]      rspValid,
   input wire logic [1:0]      rspNack,
   input wire logic [1:0][7:0] rspData
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   // Register access of master 0, or register read of master 0 or 1, being answered
   sequence regStart0;
      $rose(reqValid[0]) && !reqFar[0];
   endsequence
   sequence answer0;
      ##[1:4] rspValid[0];
   endsequence
   sequence regRead0;
      rspValid[0] && !reqWrite[0] && !reqFar[0];
   endsequence
   sequence regRead1;
      rspValid[1] && !reqWrite[1] && !reqFar[1];
   endsequence

   rsp_has_req_a : assert property (
      rspValid[0] |-> reqValid[0]) else $error("answer without request");
   rsp_pulse_a : assert property (
      rspValid[1] |=> !rspValid[1]) else $error("answer longer than one");
   req_hold_a : assert property (
      reqValid[1] && !rspValid[1] |=> reqValid[1] && $stable(reqAddr[1]))
      else $error("request dropped early");
   reg_answer_a : assert property (
      regStart0 |-> answer0) else $error("register access not answered");
   reg_no_nack_a : assert property (
      rspValid[0] && !reqFar[0] |-> !rspNack[0])
      else $error("register access refused");
   reset_reads_a : assert property (
      regRead0 and reqAddr[0] == 8'h01 |-> rspData[0][6:0] == 7'h00)
      else $error("reset bits read nonzero");
   config_rsvd_a : assert property (
      regRead1 and reqAddr[1] == 8'h03 |-> (rspData[1] & 8'h4d) == 8'h00)
      else $error("reserved config bits set");
   unmapped_zero_a : assert property (
      regRead0 and reqAddr[0] == 8'h02 |-> rspData[0] == 8'h00)
      else $error("unmapped read nonzero");
endmodule

// ==== verif/tb_serializer_control_registers.sv ====
module tb_serializer_control_registers;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] STRAP = 7'h0c;
   logic [6:0] strapPin = STRAP;
   logic       ref_clk = 1'b0;
   logic       reset = 1'b1;
   logic [7:0] cmdAddr = 8'h00;
   logic [7:0] cmdWdata = 8'h00;
   logic       cmdWrite = 1'b0;
   logic       cmdRead = 1'b0;
   logic       linkDetected = 1'b1;
   logic       farDone = 1'b0;
   logic       farNack = 1'b0;
   logic [2:0] syncIn = 3'h0;
   logic [1:0] farWait = 2'h0;
   logic [7:0] cmdRdata;
   logic [2:0] syncOut;
   logic [6:0] deviceAddress0, deviceAddress1;
   logic       farReq, powerDown, crcCheckEnable, logicResetPulse;
   int         fail_count = 0, checked = 0, pulses = 0;
   scr_link_if link ();
   scr_host u_scr_host (.ref_clk(ref_clk), .reset(reset), .link(link.host),
      .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdWrite(cmdWrite),
      .cmdRead(cmdRead), .cmdRdata(cmdRdata));
   scr_device u_scr_device (.ref_clk(ref_clk), .reset(reset),
      .link(link.device), .strapAddress(strapPin),
      .linkDetected(linkDetected),
      .dataEnableInput(syncIn[0]), .horizontalSyncInput(syncIn[1]),
      .verticalSyncInput(syncIn[2]), .farReq(farReq), .farWrite(),
      .farPort(), .farAddr(), .farData(), .farDone(farDone),
      .farNack(farNack), .farRdata(8'h5a), .deviceAddress0(deviceAddress0),
      .deviceAddress1(deviceAddress1), .port1Enabled(), .powerDown(powerDown),
      .crcCheckEnable(crcCheckEnable), .pclkAutoSwitch(),
      .logicResetPulse(logicResetPulse), .syncOut(syncOut));
   scr_link_assertions u_scr_link_assertions (.ref_clk(ref_clk),
      .reset(reset), .reqValid(link.reqValid), .reqWrite(link.reqWrite),
      .reqFar(link.reqFar), .reqAddr(link.reqAddr),
      .rspValid(link.rspValid), .rspNack(link.rspNack),
      .rspData(link.rspData));

   always #5 ref_clk = ~ref_clk;

   // Far slave stalls a few cycles so the path is seen busy
   always @(posedge ref_clk) begin
      farDone <= 1'b0;
      if (farReq && !farDone)
         farWait <= farWait + 2'h1;
      if (farWait == 2'h3) begin
         farDone <= 1'b1;
         farWait <= 2'h0;
      end
      if (logicResetPulse === 1'b1)
         pulses++;
   end

   // Verdict, also reached when a wait runs out
   task automatic conclude();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   // Command port cycles: one-cycle strobes, read data the cycle after
   task automatic cmd_wr(logic [7:0] a, logic [7:0] d);
      @(posedge ref_clk);
      cmdAddr <= a;
      cmdWdata <= d;
      cmdWrite <= 1'b1;
      @(posedge ref_clk);
      cmdWrite <= 1'b0;
   endtask

   task automatic cmd_rd(logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      cmdAddr <= a;
      cmdRead <= 1'b1;
      @(posedge ref_clk);
      cmdRead <= 1'b0;
      #1 d = cmdRdata;
   endtask

   // Poll both busy bits; a stuck launch ends the run
   task automatic wait_idle();
      logic [7:0] s;
      for (int n = 0; n < 50; n++) begin
         cmd_rd(8'h03, s);
         if (s[1:0] == 2'h0)
            return;
      end
      check("busy", 8'h00, s);
      conclude();
   endtask

   task automatic access(logic [3:0] op, logic [7:0] a, logic [7:0] d);
      cmd_wr(8'h00, a);
      cmd_wr(8'h01, d);
      cmd_wr(8'h02, {4'h0, op});
      wait_idle();
   endtask

   task automatic reg_wr(logic [7:0] a, logic [7:0] d);
      access(4'h1, a, d);
   endtask

   task automatic reg_rd(logic m, logic [7:0] a, output logic [7:0] d);
      access({2'h0, m, 1'b0}, a, 8'h00);
      cmd_rd({7'h02, m}, d);
   endtask

   task automatic test_reset();
      logic [7:0] v;
      reg_rd(1'b0, 8'h00, v);
      check("address reg", {STRAP, 1'b0}, v);
      reg_rd(1'b1, 8'h01, v);
      check("reset reg", 8'h00, v);
      reg_rd(1'b0, 8'h03, v);
      check("config reg", 8'h92, v);
      reg_rd(1'b0, 8'h02, v);
      check("unmapped", 8'h00, v);
      check("port1 addr", {1'b0, STRAP + 7'h01}, {1'b0, deviceAddress1});
      check("crc enable", 8'h01, {7'h00, crcCheckEnable});
      $display("test_reset done");
   endtask

   task automatic test_address();
      reg_wr(8'h00, 8'h55);
      check("port0 addr", 8'h2a, {1'b0, deviceAddress0});
      reg_wr(8'h1e, 8'h01);
      reg_wr(8'h00, 8'h67);
      check("port1 addr", 8'h33, {1'b0, deviceAddress1});
      check("port0 kept", 8'h2a, {1'b0, deviceAddress0});
      reg_wr(8'h1e, 8'h00);
      $display("test_address done");
   endtask

   // Both masters launched back to back on one register
   task automatic test_concurrent();
      logic [7:0] v;
      cmd_wr(8'h00, 8'h03);
      cmd_wr(8'h01, 8'h10);
      cmd_wr(8'h02, 8'h01);
      cmd_wr(8'h02, 8'h02);
      wait_idle();
      cmd_rd(8'h05, v);
      check("remote read", 8'h10, v);
      check("crc enable", 8'h00, {7'h00, crcCheckEnable});
      $display("test_concurrent done");
   endtask

   task automatic test_soft_reset();
      logic [7:0] v;
      reg_wr(8'h01, 8'h80);
      @(posedge ref_clk);
      linkDetected <= 1'b0;
      repeat (5) @(posedge ref_clk);
      #1 check("power down", 8'h01, {7'h00, powerDown});
      @(posedge ref_clk);
      linkDetected <= 1'b1;
      reg_wr(8'h01, 8'h81);
      reg_rd(1'b0, 8'h03, v);
      check("config kept", 8'h10, v);
      reg_rd(1'b0, 8'h01, v);
      check("reset0 clear", 8'h80, v);
      @(posedge ref_clk);
      strapPin <= 7'h0e;
      reg_wr(8'h01, 8'h02);
      reg_rd(1'b0, 8'h00, v);
      check("strap recapture", 8'h1c, v);
      check("strap address", 8'h0e, {1'b0, deviceAddress0});
      reg_rd(1'b0, 8'h03, v);
      check("config reset", 8'h92, v);
      reg_rd(1'b0, 8'h01, v);
      check("reset1 clear", 8'h00, v);
      check("reset pulses", 8'h02, 8'(pulses));
      $display("test_soft_reset done");
   endtask

   task automatic pulse(int i, int w, output logic seen);
      seen = 1'b0;
      @(posedge ref_clk);
      syncIn[i] <= 1'b1;
      repeat (w) @(posedge ref_clk);
      syncIn[i] <= 1'b0;
      repeat (8) begin
         @(posedge ref_clk);
         #1 seen = seen | (syncOut[i] === 1'b1);
      end
   endtask

   task automatic test_filter();
      logic s;
      for (int i = 0; i < 3; i++) begin
         pulse(i, 1, s);
         check("short pulse", 8'h00, {7'h00, s});
         pulse(i, 2, s);
         check("long pulse", 8'h01, {7'h00, s});
      end
      reg_wr(8'h03, 8'h82);
      pulse(0, 1, s);
      check("unfiltered", 8'h01, {7'h00, s});
      $display("test_filter done");
   endtask

   // Remote not-acknowledge of a write shows only without auto-acknowledge
   task automatic test_far();
      logic [7:0] v;
      @(posedge ref_clk);
      farNack <= 1'b1;
      access(4'h5, 8'h40, 8'hab);
      cmd_rd(8'h03, v);
      check("far nack", 8'h04, v & 8'h04);
      cmd_wr(8'h03, 8'h04);
      reg_wr(8'h03, 8'hb2);
      access(4'h5, 8'h40, 8'hab);
      cmd_rd(8'h03, v);
      check("auto ack", 8'h00, v & 8'h04);
      access(4'h4, 8'h41, 8'h00);
      cmd_rd(8'h04, v);
      check("far rdata", 8'h5a, v);
      $display("test_far done");
   endtask

   // Host refuses launches that break direction or legacy policy
   task automatic test_policy();
      logic [7:0] v;
      cmd_wr(8'h02, 8'h06);
      cmd_rd(8'h03, v);
      check("far non-owner", 8'h10, v & 8'h13);
      cmd_wr(8'h03, 8'h10);
      cmd_wr(8'h06, 8'h02);
      cmd_wr(8'h02, 8'h02);
      cmd_rd(8'h03, v);
      check("legacy refuse", 8'h10, v & 8'h13);
      cmd_wr(8'h03, 8'h10);
      cmd_wr(8'h06, 8'h00);
      $display("test_policy done");
   endtask

   initial begin
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      test_reset();
      test_address();
      test_concurrent();
      test_soft_reset();
      test_filter();
      test_policy();
      test_far();
      conclude();
   end
endmodule
